/* tcoc_pkg.sv */
package tcoc_pkg;
    localparam int TCOC_CHANS = 4;
    localparam int ADDR_TOP_LSB = 8;
    localparam int CH_LSB = 6;
    // per-channel byte offsets, channel stride 0x40
    localparam logic [5:0] OFS_CMP1 = 6'h00;
    localparam logic [5:0] OFS_CMP2 = 6'h04;
    localparam logic [5:0] OFS_CNT = 6'h08;
    localparam logic [5:0] OFS_HOLD = 6'h0C;
    localparam logic [5:0] OFS_LOAD = 6'h10;
    localparam logic [5:0] OFS_CTRL = 6'h14;
    localparam logic [5:0] OFS_CHANNEL_STATUS_CONTROL_REG = 6'h18;
    localparam logic [5:0] OFS_STAT = 6'h1C;
    localparam logic [5:0] OFS_INTEN = 6'h20;
    localparam logic [5:0] OFS_DMAEN = 6'h24;
    // status/control bits above the stored config field
    localparam int SC_W = 6;
    localparam int SC_FORCE = 6;
    localparam int SC_CHANNEL_OUTPUT_FLAG = 7;
    localparam int SC_PIN = 8;
    localparam int CT_EN = 0;
    localparam int CT_MODE_LSB = 1;
    localparam int FL_W = 4;
    localparam int ST_C1 = 1;
    localparam int DM_C1 = 0;
    localparam int DM_C2 = 1;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef enum logic [2:0] {
        OM_NONE    = 3'b000,
        OM_CLEAR   = 3'b001,
        OM_SET     = 3'b010,
        OM_TOGGLE  = 3'b011,
        OM_TOG_ALT = 3'b100,
        OM_SET_CLR = 3'b101
    } tcoc_omode_t;

    typedef enum logic [1:0] {
        BS_IDLE   = 2'b00,
        BS_WRITE  = 2'b01,
        BS_RDWAIT = 2'b10,
        BS_RDDONE = 2'b11
    } tcoc_bus_t;

    typedef struct packed {
        logic mreinit;
        logic mforce;
        logic master;
        logic pin_en;
        logic inv;
        logic val;
    } tcoc_channel_status_control_reg_t;

    typedef struct packed {
        logic ovf;
        logic c2;
        logic c1;
        logic cmp;
    } tcoc_flags_t;

    typedef struct packed {
        logic       hit;
        logic [1:0] ch;
        logic [5:0] ofs;
    } tcoc_acc_t;
endpackage

/* tcoc_channel_ctrl.sv */
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
// Overview of operation
// - each channel has a selectable mode deciding how its output flag reacts to compare events.
// - each channel holds a value that is applied to its output flag on any force event.
// - a software force copies the stored forced value bit onto the output flag.
// - the pin shows the output flag inverted when invert is set, plain otherwise.
// - the pin is driven only while pin enable is set, otherwise it is an input.
// - a master channel broadcasts each of its compare events to all channels.
// - with master-force enabled, a broadcast compare event forces the output flag.
// - with master-reinit enabled, a broadcast compare event reloads the counter.
// - compare 1 and compare 2 DMA requests are enabled separately by mask bits.
// - compare 1 and compare 2 interrupts are enabled separately by mask bits.
// - all status flags read together as one word, including a general compare flag.
// - a counter read returns the live counter value.
// - a counter read snapshots every channel counter into its hold register.
// - writing ones to the status word clears only those flags.
module tcoc_channel_ctrl
    import tcoc_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic      [1:0]            hresp,
    input  wire logic [TCOC_CHANS-1:0] pin_i,
    output logic      [TCOC_CHANS-1:0] pin_o,
    output logic      [TCOC_CHANS-1:0] pin_oe,
    output logic      [2*TCOC_CHANS-1:0] dma_req,
    output logic                       irq
);
    logic        [15:0] cmp1  [TCOC_CHANS];
    logic        [15:0] cmp2  [TCOC_CHANS];
    logic        [15:0] cnt   [TCOC_CHANS];
    logic        [15:0] hold  [TCOC_CHANS];
    logic        [15:0] load  [TCOC_CHANS];
    logic        [1:0]  dmae  [TCOC_CHANS];
    tcoc_omode_t        mode  [TCOC_CHANS];
    tcoc_channel_status_control_reg_t        sc    [TCOC_CHANS];
    tcoc_flags_t        st    [TCOC_CHANS];
    tcoc_flags_t        ie    [TCOC_CHANS];
    logic [TCOC_CHANS-1:0] en;
    logic [TCOC_CHANS-1:0] channel_output_flag;
    logic [TCOC_CHANS-1:0] ev_c1;
    logic [TCOC_CHANS-1:0] ev_c2;
    logic [TCOC_CHANS-1:0] ev_ovf;
    logic [TCOC_CHANS-1:0] sw_force;
    logic [TCOC_CHANS-1:0] cnt_wr;
    logic [TCOC_CHANS-1:0] mst_ch;
    logic [TCOC_CHANS-1:0] irq_ch;
    logic                  mst_evt;
    logic                  wr_now;
    logic                  accept;
    logic [31:0]           rd_word;
    tcoc_acc_t             acc;
    tcoc_bus_t             bstate;
    tcoc_bus_t             next_bstate;

    function automatic logic is_acc(tcoc_acc_t a, logic [1:0] ch,
                                    logic [5:0] ofs);
        return a.hit && (a.ch == ch) && (a.ofs == ofs);
    endfunction

    // bus slave: writes take no wait, reads one wait so a read
    // straight after a write sees the written value
    assign accept = hsel && hready && htrans[1];
    assign hreadyout = (bstate != BS_RDWAIT);
    assign hresp = HRESP_OKAY;
    assign wr_now = (bstate == BS_WRITE);

    always_comb begin
        next_bstate = bstate;
        case (bstate)
            BS_RDWAIT: next_bstate = BS_RDDONE;
            default: begin
                if (accept) begin
                    next_bstate = hwrite ? BS_WRITE : BS_RDWAIT;
                end else begin
                    next_bstate = BS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bstate <= BS_IDLE;
            acc <= '0;
        end else begin
            bstate <= next_bstate;
            if (hreadyout && accept) begin
                acc.hit <= (haddr[31:ADDR_TOP_LSB] == '0);
                acc.ch <= haddr[ADDR_TOP_LSB-1:CH_LSB];
                acc.ofs <= haddr[CH_LSB-1:0];
            end
        end
    end

    genvar g;
    for (g = 0; g < TCOC_CHANS; g++) begin : g_ch
        assign ev_c1[g] = en[g] && (cnt[g] == cmp1[g]);
        assign ev_c2[g] = en[g] && (cnt[g] == cmp2[g]);
        assign ev_ovf[g] = en[g] && (cnt[g] == CNT_MAX);
        assign sw_force[g] = wr_now && is_acc(acc, 2'(g), OFS_CHANNEL_STATUS_CONTROL_REG)
                             && hwdata[SC_FORCE];
        assign cnt_wr[g] = wr_now && is_acc(acc, 2'(g), OFS_CNT);
        assign mst_ch[g] = sc[g].master && (ev_c1[g] || ev_c2[g]);
        assign irq_ch[g] = |(st[g] & ie[g]);
        assign pin_o[g] = channel_output_flag[g] ^ sc[g].inv;
        assign pin_oe[g] = sc[g].pin_en;
    end
    assign mst_evt = |mst_ch;
    assign irq = |irq_ch;

    // counter: bus write beats master reload beats compare reload
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < TCOC_CHANS; i++) begin
                cnt[i] <= CNT_RST;
            end
        end else begin
            for (int i = 0; i < TCOC_CHANS; i++) begin
                if (cnt_wr[i]) begin
                    cnt[i] <= hwdata[15:0];
                end else if (mst_evt && sc[i].mreinit) begin
                    cnt[i] <= load[i];
                end else if (ev_c1[i]) begin
                    cnt[i] <= load[i];
                end else if (en[i]) begin
                    cnt[i] <= cnt[i] + CNT_STEP;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < TCOC_CHANS; i++) begin
                cmp1[i] <= CNT_RST;
                cmp2[i] <= CNT_RST;
                load[i] <= CNT_RST;
                mode[i] <= OM_NONE;
                sc[i] <= '0;
                ie[i] <= '0;
                dmae[i] <= '0;
            end
            en <= '0;
        end else if (wr_now) begin
            for (int i = 0; i < TCOC_CHANS; i++) begin
                if (is_acc(acc, 2'(i), OFS_CMP1)) begin
                    cmp1[i] <= hwdata[15:0];
                end
                if (is_acc(acc, 2'(i), OFS_CMP2)) begin
                    cmp2[i] <= hwdata[15:0];
                end
                if (is_acc(acc, 2'(i), OFS_LOAD)) begin
                    load[i] <= hwdata[15:0];
                end
                if (is_acc(acc, 2'(i), OFS_CTRL)) begin
                    en[i] <= hwdata[CT_EN];
                    mode[i] <= tcoc_omode_t'(hwdata[CT_MODE_LSB +: 3]);
                end
                if (is_acc(acc, 2'(i), OFS_CHANNEL_STATUS_CONTROL_REG)) begin
                    sc[i] <= tcoc_channel_status_control_reg_t'(hwdata[SC_W-1:0]);
                end
                if (is_acc(acc, 2'(i), OFS_INTEN)) begin
                    ie[i] <= tcoc_flags_t'(hwdata[FL_W-1:0]);
                end
                if (is_acc(acc, 2'(i), OFS_DMAEN)) begin
                    dmae[i] <= hwdata[1:0];
                end
            end
        end
    end

    // sticky flags: a set in the clearing cycle survives
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < TCOC_CHANS; i++) begin
                st[i] <= '0;
            end
        end else begin
            for (int i = 0; i < TCOC_CHANS; i++) begin
                st[i] <= (st[i] & ~((wr_now && is_acc(acc, 2'(i), OFS_STAT))
                         ? tcoc_flags_t'(hwdata[FL_W-1:0]) : '0))
                         | {ev_ovf[i], ev_c2[i], ev_c1[i],
                            ev_c1[i] || ev_c2[i]};
            end
        end
    end

    // force uses the stored value, not one written alongside it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            channel_output_flag <= '0;
        end else begin
            for (int i = 0; i < TCOC_CHANS; i++) begin
                if (sw_force[i]) begin
                    channel_output_flag[i] <= sc[i].val;
                end else if (mst_evt && sc[i].mforce) begin
                    channel_output_flag[i] <= sc[i].val;
                end else begin
                    case (mode[i])
                        OM_CLEAR: if (ev_c1[i]) channel_output_flag[i] <= 1'h0;
                        OM_SET: if (ev_c1[i]) channel_output_flag[i] <= 1'h1;
                        OM_TOGGLE: if (ev_c1[i]) channel_output_flag[i] <= ~channel_output_flag[i];
                        OM_TOG_ALT: begin
                            if (ev_c1[i] || ev_c2[i]) channel_output_flag[i] <= ~channel_output_flag[i];
                        end
                        OM_SET_CLR: begin
                            if (ev_c1[i]) begin
                                channel_output_flag[i] <= 1'h1;
                            end else if (ev_c2[i]) begin
                                channel_output_flag[i] <= 1'h0;
                            end
                        end
                        default: channel_output_flag[i] <= channel_output_flag[i];
                    endcase
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_req <= '0;
        end else begin
            for (int i = 0; i < TCOC_CHANS; i++) begin
                dma_req[2*i] <= dmae[i][DM_C1] && ev_c1[i];
                dma_req[2*i+1] <= dmae[i][DM_C2] && ev_c2[i];
            end
        end
    end

    always_comb begin
        rd_word = WORD_ZERO;
        if (!acc.hit) begin
            rd_word = WORD_ZERO;
        end else if (acc.ofs == OFS_CMP1) begin
            rd_word[15:0] = cmp1[acc.ch];
        end else if (acc.ofs == OFS_CMP2) begin
            rd_word[15:0] = cmp2[acc.ch];
        end else if (acc.ofs == OFS_CNT) begin
            rd_word[15:0] = cnt[acc.ch];
        end else if (acc.ofs == OFS_HOLD) begin
            rd_word[15:0] = hold[acc.ch];
        end else if (acc.ofs == OFS_LOAD) begin
            rd_word[15:0] = load[acc.ch];
        end else if (acc.ofs == OFS_CTRL) begin
            rd_word[CT_MODE_LSB +: 3] = mode[acc.ch];
            rd_word[CT_EN] = en[acc.ch];
        end else if (acc.ofs == OFS_CHANNEL_STATUS_CONTROL_REG) begin
            rd_word[SC_W-1:0] = sc[acc.ch];
            rd_word[SC_CHANNEL_OUTPUT_FLAG] = channel_output_flag[acc.ch];
            rd_word[SC_PIN] = pin_i[acc.ch];
        end else if (acc.ofs == OFS_STAT) begin
            rd_word[FL_W-1:0] = st[acc.ch];
        end else if (acc.ofs == OFS_INTEN) begin
            rd_word[FL_W-1:0] = ie[acc.ch];
        end else if (acc.ofs == OFS_DMAEN) begin
            rd_word[1:0] = dmae[acc.ch];
        end
    end

    // live sample and hold snapshot share one edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= WORD_ZERO;
            for (int i = 0; i < TCOC_CHANS; i++) begin
                hold[i] <= CNT_RST;
            end
        end else if (bstate == BS_RDWAIT) begin
            hrdata <= rd_word;
            if (acc.hit && acc.ofs == OFS_CNT) begin
                for (int i = 0; i < TCOC_CHANS; i++) begin
                    hold[i] <= cnt[i];
                end
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_rd_req;
        accept && hreadyout && !hwrite;
    endsequence
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    a_read_wait: assert property (s_rd_req |=> s_rd_wait)
        else $error("read data phase not one wait state");
    a_cnt_live: assert property ((bstate == BS_RDWAIT && acc.hit
        && acc.ofs == OFS_CNT) |=> hrdata[15:0] == $past(cnt[acc.ch]))
        else $error("counter read not live value");
    a_hold_snap: assert property ((bstate == BS_RDWAIT && acc.hit
        && acc.ofs == OFS_CNT) |=> hold[3] == $past(cnt[3]))
        else $error("hold not captured on counter read");
    a_sw_force: assert property (sw_force[0]
        |=> channel_output_flag[0] == $past(sc[0].val))
        else $error("software force did not copy value");
    a_mst_force: assert property ((mst_evt && sc[2].mforce && !sw_force[2])
        |=> channel_output_flag[2] == $past(sc[2].val))
        else $error("master force not applied");
    a_mst_ignore: assert property ((mst_evt && !sc[1].mforce
        && !sw_force[1] && !ev_c1[1] && !ev_c2[1])
        |=> channel_output_flag[1] == $past(channel_output_flag[1]))
        else $error("master force applied while disabled");
    a_mst_reinit: assert property ((mst_evt && sc[3].mreinit && !cnt_wr[3])
        |=> cnt[3] == $past(load[3]))
        else $error("master reinit not applied");
    a_mode_set: assert property ((mode[1] == OM_SET && ev_c1[1]
        && !sw_force[1] && !(mst_evt && sc[1].mforce)) |=> channel_output_flag[1])
        else $error("set-on-compare mode failed");
    a_pin_drive: assert property ((!sc[0].pin_en |-> !pin_oe[0])
        and (sc[0].inv |-> pin_o[0] != channel_output_flag[0]))
        else $error("pin drive or polarity wrong");
    a_dma_req: assert property ((ev_c1[1] && dmae[1][DM_C1])
        |=> dma_req[2])
        else $error("compare 1 dma request missing");
    a_dma_mask: assert property (!(ev_c1[1] && dmae[1][DM_C1])
        |=> !dma_req[2])
        else $error("compare 1 dma request not masked");
    a_dma_cmp2: assert property ((ev_c2[1] && dmae[1][DM_C2])
        |=> dma_req[3])
        else $error("compare 2 dma request missing");
    a_dma_mask2: assert property (!(ev_c2[1] && dmae[1][DM_C2])
        |=> !dma_req[3])
        else $error("compare 2 dma request not masked");
    a_ovf_flag: assert property (ev_ovf[1] |=> st[1].ovf)
        else $error("overflow flag not set");
    a_flag_clear: assert property ((wr_now && is_acc(acc, 2'h1, OFS_STAT)
        && hwdata[ST_C1] && !ev_c1[1]) |=> !st[1].c1)
        else $error("flag not cleared by write one");
    a_set_wins: assert property (ev_c1[0] |=> st[0].c1 && st[0].cmp)
        else $error("compare flag lost");
    a_irq_level: assert property ((ev_c2[1] && ie[1].c2) |=> irq)
        else $error("enabled flag did not raise irq");
endmodule

/* tcoc_channel_ctrl_test.sv */
`timescale 1ns/1ps
module tcoc_channel_ctrl_test
    import tcoc_pkg::*;
;
    logic                    hclk;
    logic                    hresetn;
    logic                    hsel;
    logic [31:0]             haddr;
    logic [1:0]              htrans;
    logic                    hwrite;
    logic [2:0]              hsize;
    logic [31:0]             hwdata;
    logic [31:0]             hrdata;
    logic                    hreadyout;
    logic [1:0]              hresp;
    logic [TCOC_CHANS-1:0]   pin_i;
    logic [TCOC_CHANS-1:0]   pin_o;
    logic [TCOC_CHANS-1:0]   pin_oe;
    logic [2*TCOC_CHANS-1:0] dma_req;
    logic                    irq;
    int                      errors;
    int                      num_checks;
    logic [31:0]             dcnt [8] = '{default: 32'h0};

    tcoc_channel_ctrl tcoc_channel_ctrl_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe),
        .dma_req(dma_req), .irq(irq)
    );

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // pulses are counted, not latched, so a double pulse is caught
    always @(posedge hclk) begin
        for (int i = 0; i < 8; i++) begin
            if (dma_req[i] === 1'b1) begin
                dcnt[i] <= dcnt[i] + 32'h1;
            end
        end
    end

    task automatic wrap_up();
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] ad(input int ch, input logic [5:0] ofs);
        return {24'h0, ch[1:0], ofs};
    endfunction

    // ready is looked at on the falling edge, so it equals its value
    // at the next rising edge without racing the design's flops
    task automatic wait_rdy(output logic [31:0] rd);
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1 && n < 20) begin
            n++;
            @(negedge hclk);
        end
        chk(32'(hresp), 32'(HRESP_OKAY));
        rd = hrdata;
        @(posedge hclk);
    endtask

    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] rd);
        logic [31:0] tmp;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_rdy(tmp);
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy(rd);
        #1;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] tmp;
        xfer(1'b1, a, d, tmp);
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        xfer(1'b0, a, 32'h0, r);
    endtask

    // forced value is stored first, force issued with counter stopped
    task automatic set_flag(input int ch, input logic v,
                            input logic [31:0] extra);
        wr(ad(ch, OFS_CHANNEL_STATUS_CONTROL_REG), extra | 32'(v));
        wr(ad(ch, OFS_CHANNEL_STATUS_CONTROL_REG), extra | 32'(v) | 32'h40);
    endtask

    function automatic logic exp_of(input int m, input logic c2, input logic s);
        case (m)
            1: return c2 ? s : 1'b0;
            2: return c2 ? s : 1'b1;
            3: return c2 ? s : ~s;
            4: return ~s;
            5: return ~c2;
            default: return s;
        endcase
    endfunction

    task automatic t_reset();
        logic [31:0] r;
        chk(32'({pin_oe, pin_o, dma_req, irq}), 32'h0);
        for (int ch = 0; ch < TCOC_CHANS; ch++) begin
            rd(ad(ch, OFS_CHANNEL_STATUS_CONTROL_REG), r);
            chk(r & 32'hFF, 32'h0);
            rd(ad(ch, OFS_INTEN), r);
            chk(r, 32'h0);
            rd(ad(ch, OFS_DMAEN), r);
            chk(r, 32'h0);
        end
        rd(32'h0000_0100, r);
        chk(r, 32'h0);
        rd(ad(0, 6'h3C), r);
        chk(r, 32'h0);
    endtask

    task automatic t_pins();
        logic [31:0] r;
        pin_i <= 4'hA;
        for (int ch = 0; ch < TCOC_CHANS; ch++) begin
            rd(ad(ch, OFS_CHANNEL_STATUS_CONTROL_REG), r);
            chk(32'(r[SC_PIN]), 32'(ch % 2));
        end
        set_flag(0, 1'b1, 32'h4);
        chk(32'(pin_oe[0]), 32'h1);
        chk(32'(pin_o[0]), 32'h1);
        rd(ad(0, OFS_CHANNEL_STATUS_CONTROL_REG), r);
        chk(32'(r[SC_CHANNEL_OUTPUT_FLAG]), 32'h1);
        wr(ad(0, OFS_CHANNEL_STATUS_CONTROL_REG), 32'h7);
        chk(32'(pin_o[0]), 32'h0);
        set_flag(0, 1'b0, 32'h6);
        chk(32'(pin_o[0]), 32'h1);
        rd(ad(0, OFS_CHANNEL_STATUS_CONTROL_REG), r);
        chk(32'(r[SC_CHANNEL_OUTPUT_FLAG]), 32'h0);
        wr(ad(0, OFS_CHANNEL_STATUS_CONTROL_REG), 32'h0);
        chk(32'(pin_oe[0]), 32'h0);
    endtask

    // one compare event per pass: counter preset onto a compare value,
    // enabled for one write and stopped again before it comes round
    task automatic t_modes();
        logic [31:0] r;
        logic [31:0] d0;
        logic [31:0] d1;
        wr(ad(1, OFS_CMP1), 32'h50);
        wr(ad(1, OFS_CMP2), 32'h60);
        wr(ad(1, OFS_LOAD), 32'h0);
        // enables swapped per pass so each compare 1 and compare 2 mask bit is seen on and off
        for (int s = 0; s < 2; s++) begin
            wr(ad(1, OFS_DMAEN), s ? 32'h2 : 32'h1);
            wr(ad(1, OFS_INTEN), s ? 32'h2 : 32'h4);
            for (int m = 0; m < 6; m++) begin
                for (int e = 0; e < 2; e++) begin
                    set_flag(1, s[0], 32'h0);
                    wr(ad(1, OFS_STAT), 32'hF);
                    wr(ad(1, OFS_CNT), e ? 32'h60 : 32'h50);
                    d0 = dcnt[2];
                    d1 = dcnt[3];
                    wr(ad(1, OFS_CTRL), 32'(m * 2 + 1));
                    wr(ad(1, OFS_CTRL), 32'h0);
                    rd(ad(1, OFS_CHANNEL_STATUS_CONTROL_REG), r);
                    chk(32'(r[SC_CHANNEL_OUTPUT_FLAG]), 32'(exp_of(m, e[0], s[0])));
                    chk(dcnt[2] - d0, 32'(s == 0 && e == 0));
                    chk(dcnt[3] - d1, 32'(s == 1 && e == 1));
                    chk(32'(irq), 32'(s[0] ^ e[0]));
                    rd(ad(1, OFS_STAT), r);
                    chk(r, e ? 32'h5 : 32'h3);
                    wr(ad(1, OFS_STAT), e ? 32'h4 : 32'h2);
                    rd(ad(1, OFS_STAT), r);
                    chk(r, 32'h1);
                    chk(32'(irq), 32'h0);
                end
            end
        end
    endtask

    task automatic t_master();
        logic [31:0] r;
        logic [31:0] a;
        wr(ad(3, OFS_LOAD), 32'h123);
        wr(ad(3, OFS_CNT), 32'h777);
        wr(ad(1, OFS_CNT), 32'h444);
        set_flag(2, 1'b0, 32'h10);
        wr(ad(2, OFS_CHANNEL_STATUS_CONTROL_REG), 32'h11);
        set_flag(1, 1'b0, 32'h0);
        wr(ad(1, OFS_CHANNEL_STATUS_CONTROL_REG), 32'h1);
        wr(ad(3, OFS_CHANNEL_STATUS_CONTROL_REG), 32'h20);
        wr(ad(0, OFS_CHANNEL_STATUS_CONTROL_REG), 32'h8);
        wr(ad(0, OFS_CMP1), 32'h50);
        wr(ad(0, OFS_CNT), 32'h50);
        wr(ad(0, OFS_CTRL), 32'h1);
        wr(ad(0, OFS_CTRL), 32'h0);
        rd(ad(2, OFS_CHANNEL_STATUS_CONTROL_REG), r);
        chk(32'(r[SC_CHANNEL_OUTPUT_FLAG]), 32'h1);
        rd(ad(1, OFS_CHANNEL_STATUS_CONTROL_REG), r);
        chk(32'(r[SC_CHANNEL_OUTPUT_FLAG]), 32'h0);
        rd(ad(3, OFS_CNT), r);
        chk(r, 32'h123);
        rd(ad(1, OFS_CNT), r);
        chk(r, 32'h444);
        rd(ad(3, OFS_HOLD), r);
        chk(r, 32'h123);
        // reads are three cycles apart with no address overlap
        wr(ad(1, OFS_CTRL), 32'h1);
        rd(ad(1, OFS_CNT), a);
        rd(ad(1, OFS_CNT), r);
        chk(r - a, 32'h3);
        wr(ad(1, OFS_CTRL), 32'h0);
        rd(ad(1, OFS_HOLD), a);
        chk(a, r);
        wr(ad(1, OFS_STAT), 32'hF);
        wr(ad(1, OFS_CNT), 32'hFFFF);
        wr(ad(1, OFS_CTRL), 32'h1);
        wr(ad(1, OFS_CTRL), 32'h0);
        rd(ad(1, OFS_STAT), r);
        chk(r, 32'h8);
    endtask

    initial begin
        #200000;
        errors++;
        wrap_up();
    end

    initial begin
        errors = 0;
        num_checks = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pin_i = 4'h5;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        t_reset();
        t_pins();
        t_modes();
        t_master();
        wrap_up();
    end
endmodule
